/* hw/cfm_filter.sv */
// CAN receive acceptance filter: identifier part with APB register access
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Each standard identifier bit of a frame must equal the stored filter bit to match.
// - With type enable set and the format select set, only extended frames can match.
// - With type enable set and format select clear only standard frames match; else format is ignored.
// - Extended identifier bits 17 and 16 sit in filter bits 1:0 and must equal the received bits on extended frames only.
// - Filter bits 4 and 2 are unused and always read as zero.
// - The eleven-bit standard identifier value is stored in filter bits 15 down to 5.
module cfm_filter
  import cfm_pkg::*;
(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Receive path
  input  wire logic          rx_valid,
  input  wire cfm_rx_ident_t rx_ident,
  // Filter result
  output logic               match_valid,
  output logic               match_hit
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  cfm_filter_t filter_r;
  cfm_filter_t filter_nxt;
  logic        type_en_r;
  logic        type_en_nxt;
  logic        sticky_r;
  logic        sticky_nxt;
  logic        last_hit_r;
  logic        last_hit_nxt;
  logic        seen_r;
  logic        seen_nxt;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic        mvalid_r;
  logic        mvalid_nxt;
  logic        mhit_r;
  logic        mhit_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        err_r;
  logic        err_nxt;

  logic        setup;
  logic        wr_en;
  logic        mapped;
  logic [31:0] rd_mux;
  logic [15:0] filter_word;
  logic        std_ok;
  logic        ext_ok;
  logic        fmt_ok;
  logic        hit;

  ////////////////////////////////////////////////////////////////////////////
  // Identifier compare
  always_comb begin
    std_ok = (rx_ident.std_ident_field == filter_r.std_ident_field);
    // Standard frames carry no extended bits, so those bits only count for extended frames
    ext_ok = !rx_ident.is_extended ||
             (rx_ident.ext_ident_field == filter_r.ext_ident_field);
    // Format select only counts while the type enable is set
    if (type_en_r) begin
      fmt_ok = (rx_ident.is_extended == filter_r.frame_format_select);
    end else begin
      fmt_ok = 1'b1;
    end
    hit = std_ok && ext_ok && fmt_ok;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode and read mux
  always_comb begin
    setup  = psel && !penable;
    wr_en  = psel && penable && pwrite;
    // Unmapped offsets answer with an error rather than a bus hang
    mapped = (paddr == CFM_FILTER_OFS) || (paddr == CFM_CTRL_OFS) ||
             (paddr == CFM_STATUS_OFS) || (paddr == CFM_COUNT_OFS);
    filter_word = 16'h0000;
    filter_word[CFM_STD_MSB:CFM_STD_LSB] = filter_r.std_ident_field;
    filter_word[CFM_FMT_BIT] = filter_r.frame_format_select;
    filter_word[CFM_EXT_MSB:CFM_EXT_LSB] = filter_r.ext_ident_field;
    // Bits 4 and 2 are never stored, so they read back as zero
    rd_mux = 32'h0000_0000;
    case (paddr)
      CFM_FILTER_OFS: begin
        rd_mux[15:0] = filter_word;
      end
      CFM_CTRL_OFS: begin
        rd_mux[CFM_TYPE_EN_BIT] = type_en_r;
      end
      CFM_STATUS_OFS: begin
        rd_mux[CFM_STICKY_BIT]   = sticky_r;
        rd_mux[CFM_LAST_HIT_BIT] = last_hit_r;
        rd_mux[CFM_SEEN_BIT]     = seen_r;
      end
      CFM_COUNT_OFS: begin
        rd_mux[15:0] = count_r;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    filter_nxt   = filter_r;
    type_en_nxt  = type_en_r;
    sticky_nxt   = sticky_r;
    last_hit_nxt = last_hit_r;
    seen_nxt     = seen_r;
    count_nxt    = count_r;
    rdata_nxt    = rdata_r;
    err_nxt      = err_r;
    mvalid_nxt   = rx_valid;
    mhit_nxt     = rx_valid && hit;

    // Read data captured in setup so the access phase answers from flops
    if (setup) begin
      rdata_nxt = pwrite ? 32'h0000_0000 : rd_mux;
      err_nxt   = !mapped;
    end

    if (wr_en) begin
      case (paddr)
        CFM_FILTER_OFS: begin
          filter_nxt.std_ident_field     = pwdata[CFM_STD_MSB:CFM_STD_LSB];
          filter_nxt.frame_format_select = pwdata[CFM_FMT_BIT];
          filter_nxt.ext_ident_field     = pwdata[CFM_EXT_MSB:CFM_EXT_LSB];
        end
        CFM_CTRL_OFS: begin
          type_en_nxt = pwdata[CFM_TYPE_EN_BIT];
        end
        CFM_STATUS_OFS: begin
          if (pwdata[CFM_STICKY_BIT]) begin
            sticky_nxt = 1'b0;
          end
        end
        CFM_COUNT_OFS: begin
          count_nxt = CFM_COUNT_RST;
        end
        default: begin
          filter_nxt = filter_r;
        end
      endcase
    end

    // Receive events come last so a hit in a clearing cycle is kept
    if (rx_valid) begin
      seen_nxt     = 1'b1;
      last_hit_nxt = hit;
      if (hit) begin
        sticky_nxt = 1'b1;
        // Clear and hit together leave exactly one counted hit
        if (wr_en && (paddr == CFM_COUNT_OFS)) begin
          count_nxt = 16'h0001;
        end else if (count_r != CFM_COUNT_MAX) begin
          // Saturates rather than wraps so software never misreads a rollover
          count_nxt = count_r + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Fields follow the register layout, not the packed order
      filter_r.std_ident_field     <= CFM_FILTER_RST[CFM_STD_MSB:CFM_STD_LSB];
      filter_r.frame_format_select <= CFM_FILTER_RST[CFM_FMT_BIT];
      filter_r.ext_ident_field     <= CFM_FILTER_RST[CFM_EXT_MSB:CFM_EXT_LSB];
      type_en_r  <= CFM_TYPE_EN_RST;
      sticky_r   <= 1'b0;
      last_hit_r <= 1'b0;
      seen_r     <= 1'b0;
      count_r    <= CFM_COUNT_RST;
      rdata_r    <= 32'h0000_0000;
      err_r      <= 1'b0;
      mvalid_r   <= 1'b0;
      mhit_r     <= 1'b0;
    end else begin
      filter_r   <= filter_nxt;
      type_en_r  <= type_en_nxt;
      sticky_r   <= sticky_nxt;
      last_hit_r <= last_hit_nxt;
      seen_r     <= seen_nxt;
      count_r    <= count_nxt;
      rdata_r    <= rdata_nxt;
      err_r      <= err_nxt;
      mvalid_r   <= mvalid_nxt;
      mhit_r     <= mhit_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Zero wait states: the access phase always completes at its first edge
  assign pready      = 1'b1;
  // Error shown only in the access phase, where the master samples it
  assign pslverr     = psel && penable && err_r;
  assign prdata      = rdata_r;
  assign match_valid = mvalid_r;
  assign match_hit   = mhit_r;

endmodule

/* hw/cfm_pkg.sv */
// Package: register map, field layout and carrier types for the CAN ID acceptance filter
package cfm_pkg;

  // Register byte offsets
  localparam logic [11:0] CFM_FILTER_OFS = 12'h000;
  localparam logic [11:0] CFM_CTRL_OFS   = 12'h004;
  localparam logic [11:0] CFM_STATUS_OFS = 12'h008;
  localparam logic [11:0] CFM_COUNT_OFS  = 12'h00C;

  // Filter register field positions
  localparam int CFM_STD_LSB = 5;
  localparam int CFM_STD_MSB = 15;
  localparam int CFM_FMT_BIT = 3;
  localparam int CFM_EXT_LSB = 0;
  localparam int CFM_EXT_MSB = 1;

  // Control and status field positions
  localparam int CFM_TYPE_EN_BIT  = 0;
  localparam int CFM_STICKY_BIT   = 0;
  localparam int CFM_LAST_HIT_BIT = 1;
  localparam int CFM_SEEN_BIT     = 2;

  // Values after reset, and the count saturation limit
  localparam logic [15:0] CFM_FILTER_RST = 16'h0000;
  localparam logic        CFM_TYPE_EN_RST = 1'b0;
  localparam logic [15:0] CFM_COUNT_RST  = 16'h0000;
  localparam logic [15:0] CFM_COUNT_MAX  = 16'hFFFF;

  // Identifier as presented by the receive path
  typedef struct packed {
    logic [10:0] std_ident_field;
    logic [1:0]  ext_ident_field;
    logic        is_extended;
  } cfm_rx_ident_t;

  // Stored filter contents
  typedef struct packed {
    logic [10:0] std_ident_field;
    logic        frame_format_select;
    logic [1:0]  ext_ident_field;
  } cfm_filter_t;

endpackage

/* verif/cfm_filter_asserts.sv */
// Checker for the CAN identifier filter
`timescale 1ns/1ps
module cfm_filter_asserts import cfm_pkg::*; (
  // Clock and reset
  input wire logic          pclk,
  input wire logic          presetn,
  // APB
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  // Receive and result
  input wire logic          rx_valid,
  input wire logic          match_valid,
  input wire logic          match_hit,
  input wire cfm_rx_ident_t rx_ident
);
  logic [15:0] f_r;
  logic        t_r;
  wire sm = rx_ident.std_ident_field == f_r[15:5];
  wire em = !rx_ident.is_extended || rx_ident.ext_ident_field == f_r[1:0];
  wire fm = !t_r || rx_ident.is_extended == f_r[3];
  wire hm = sm && em && fm;
  wire rf = psel && penable && !pwrite && paddr == 12'h000;
  // Shadow of filter and type enable, from bus writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_r <= 16'h0000;
      t_r <= 1'b0;
    end else if (psel && penable && pwrite) begin
      if (paddr == 12'h000) f_r <= pwdata[15:0];
      if (paddr == 12'h004) t_r <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_std_bits: assert property (rx_valid && !sm |=> !match_hit) else $error("std hit");
  a_only_ext: assert property (rx_valid && t_r && f_r[3] && !rx_ident.is_extended
    |=> !match_hit) else $error("std frame hit");
  a_only_std: assert property (rx_valid && t_r && !f_r[3] && rx_ident.is_extended
    |=> !match_hit) else $error("ext frame hit");
  a_ext_bits: assert property (rx_valid && !em |=> !match_hit) else $error("ext hit");
  a_unused_zero: assert property (rf |-> prdata[4] == 0 && prdata[2] == 0)
    else $error("unused bit set");
  a_std_field: assert property (rf |-> prdata[15:5] == f_r[15:5]) else $error("std field");
  a_hit_exact: assert property (rx_valid |=> match_valid && match_hit == $past(hm))
    else $error("hit wrong");
  a_no_spurious: assert property (!rx_valid |=> !match_valid && !match_hit)
    else $error("spurious");
  c_hit: cover property (rx_valid ##1 match_hit);
  c_ext_only: cover property (rx_valid && t_r && f_r[3]);
  c_miss: cover property (match_valid && !match_hit);
endmodule
bind cfm_filter cfm_filter_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .rx_valid(rx_valid), .match_valid(match_valid), .match_hit(match_hit), .rx_ident(rx_ident));

/* verif/cfm_filter_tb.sv */
// Testbench for the CAN identifier filter
`timescale 1ns/1ps
module cfm_filter_tb import cfm_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, rx_valid, match_valid, match_hit;
  cfm_rx_ident_t rx_ident;
  int n_fail = 0, total_checks = 0, cyc = 0;
  initial forever #20 pclk = ~pclk;
  cfm_rx_model rxm (.pclk(pclk), .rx_valid(rx_valid), .rx_ident(rx_ident));
  cfm_filter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_ident(rx_ident),
    .match_valid(match_valid), .match_hit(match_hit));
  task automatic end_of_test();
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input logic [10:0] s, input logic [1:0] e, input logic x, h);
    rxm.send('{s, e, x});
    #1;
    chk({31'h0, match_valid}, 32'h1);
    chk({31'h0, match_hit}, {31'h0, h});
  endtask
  task automatic t_layout();
    apb(1'b0, CFM_FILTER_OFS, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h0);
    chk({31'h0, pready}, 32'h1);
    apb(1'b1, CFM_FILTER_OFS, 32'hFFFF_FFFF);
    apb(1'b0, CFM_FILTER_OFS, 32'h0);
    chk(rd, 32'h0000_FFEB);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, er}, 32'h1);
  endtask
  task automatic t_std_bits();
    apb(1'b1, CFM_FILTER_OFS, 32'h0000_B4A0);
    apb(1'b0, CFM_FILTER_OFS, 32'h0);
    chk(rd, 32'h0000_B4A0);
    frame(11'h5A5, 2'b01, 1'b0, 1'b1);
    for (int i = 0; i < 11; i++) frame(11'h5A5 ^ (11'h1 << i), 2'b00, 1'b0, 1'b0);
  endtask
  task automatic t_ext_bits();
    apb(1'b1, CFM_FILTER_OFS, 32'h0000_B4A2);
    for (int j = 0; j < 4; j++) frame(11'h5A5, 2'(j), 1'b1, j == 2);
  endtask
  // Every type enable, format select and frame kind
  task automatic t_type();
    for (int te = 0; te < 2; te++)
      for (int fm = 0; fm < 2; fm++) begin
        apb(1'b1, CFM_CTRL_OFS, 32'(te));
        apb(1'b1, CFM_FILTER_OFS, 32'h0000_B4A2 | 32'(fm << 3));
        for (int x = 0; x < 2; x++) frame(11'h5A5, 2'b10, 1'(x), te == 0 || x == fm);
      end
  endtask
  // Status and count follow hits; a clear in the cycle of a hit loses to it for sticky and leaves a count of one
  task automatic t_status();
    apb(1'b0, CFM_CTRL_OFS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, CFM_STATUS_OFS, 32'h1);
    apb(1'b1, CFM_COUNT_OFS, 32'h0);
    apb(1'b0, CFM_STATUS_OFS, 32'h0);
    chk(rd, 32'h6);
    frame(11'h5A5, 2'b10, 1'b0, 1'b0);
    apb(1'b0, CFM_STATUS_OFS, 32'h0);
    chk(rd, 32'h4);
    repeat (2) frame(11'h5A5, 2'b10, 1'b1, 1'b1);
    apb(1'b0, CFM_COUNT_OFS, 32'h0);
    chk(rd, 32'h2);
    fork
      apb(1'b1, CFM_STATUS_OFS, 32'h1);
      begin
        @(posedge pclk);
        rxm.send('{11'h5A5, 2'b10, 1'b1});
      end
    join
    apb(1'b0, CFM_STATUS_OFS, 32'h0);
    chk(rd, 32'h7);
    fork
      apb(1'b1, CFM_COUNT_OFS, 32'h0);
      begin
        @(posedge pclk);
        rxm.send('{11'h5A5, 2'b10, 1'b1});
      end
    join
    apb(1'b0, CFM_COUNT_OFS, 32'h0);
    chk(rd, 32'h1);
  endtask
  // Reset in mid-run brings every register back to its reset value
  task automatic t_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CFM_FILTER_OFS, 32'h0);
    chk(rd, {16'h0000, CFM_FILTER_RST});
    apb(1'b0, CFM_CTRL_OFS, 32'h0);
    chk(rd, {31'h0, CFM_TYPE_EN_RST});
    apb(1'b0, CFM_STATUS_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, CFM_COUNT_OFS, 32'h0);
    chk(rd, {16'h0000, CFM_COUNT_RST});
    frame(11'h000, 2'b00, 1'b1, 1'b1);
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_layout();
    t_std_bits();
    t_ext_bits();
    t_type();
    t_status();
    t_reset();
    end_of_test();
  end
endmodule

/* verif/cfm_rx_model.sv */
// Receive path model presenting frame identifiers
`timescale 1ns/1ps
module cfm_rx_model import cfm_pkg::*; (
  input wire logic pclk,
  output logic          rx_valid,
  output cfm_rx_ident_t rx_ident
);
  initial begin
    rx_valid = 1'b0;
    rx_ident = '0;
  end
  // Identifier inverted after the strobe so a stale value cannot pass
  task automatic send(input cfm_rx_ident_t id);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_ident <= id;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_ident <= ~id;
  endtask
endmodule
